// [cdr_control_status_regs.v]
// Control and status register bank of a clock-and-data-recovery receiver, with its
// two-wire management slave. The bus clock and data are sampled by sys_clk_i, which must
// run at least eight times faster than the bus clock. All loop-side inputs are levels.
// Function
// - Writable registers reset to zero.
// - Status D5 shows loss of signal.
// - Status D4 latches loss of lock until cleared.
// - Status D3 is one while acquiring lock.
// - Status D2 is one when measurement completes.
// - Lock setup D1 write starts rate measurement.
// - Lock setup D0 selects data or reference lock.
// - Reference range D7:D6, divide exponent D5:D2.
// - Config D7 makes lock-lost pin static.
// - Reset bits act on one-then-zero writes.
// - Output config sets polarity and suppression mode.
// - Coarse rate nine bits, LSB in status.
// - Lock-lost pin active high when unlocked.
// - Suppression input disables data output, and clock output unless split.
`timescale 1ns/1ps
`include "cdr_regs_consts.vh"

module cdr_control_status_regs
#(
   parameter [6:0] BASE_ADDR = 7'h40 // Arbitrary value; bit 5 comes from the address strap.
)
(
   // Clock and reset
   input  wire                      sys_clk_i,
   input  wire                      rst_n_i,
   // Management bus
   input  wire                      scl_i,
   input  wire                      sda_i,
   output reg                       sda_o,
   output reg                       sda_oe_n_o,
   input  wire                      saddr5_i,
   // Recovery loop status
   input  wire                      locked_i,
   input  wire                      signal_lost_i,
   input  wire                      measure_done_i,
   input  wire [`FREQ_WORD_W-1:0]   freq_word_i,
   input  wire [`COARSE_RATE_W-1:0] coarse_rate_i,
   input  wire                      suppress_i,
   // Loop control
   output wire [1:0]                ref_range_o,
   output wire [3:0]                div_exp_o,
   output wire                      lock_to_ref_o,
   output reg                       measure_start_o,
   output reg                       system_reset_o,
   // Status pins and output suppression
   output reg                       lock_lost_o,
   output reg                       signal_lost_o,
   output reg                       suppress_clk_o,
   output reg                       suppress_data_o
);

   localparam IN_W = 7 + `FREQ_WORD_W + `COARSE_RATE_W;

   localparam [2:0] ST_IDLE     = 3'h0;
   localparam [2:0] ST_ADDR     = 3'h1;
   localparam [2:0] ST_ADDR_ACK = 3'h2;
   localparam [2:0] ST_WBYTE    = 3'h3;
   localparam [2:0] ST_WACK     = 3'h4;
   localparam [2:0] ST_READ     = 3'h5;
   localparam [2:0] ST_RACK     = 3'h6;

   wire [IN_W-1:0]               in_sync;
   wire                          scl_s;
   wire                          sda_s;
   wire                          saddr5_s;
   wire                          locked_s;
   wire                          lost_s;
   wire                          done_s;
   wire                          suppress_s;
   wire [`FREQ_WORD_W-1:0]       freq_s;
   wire [`COARSE_RATE_W-1:0]     coarse_s;

   reg                           scl_prev_q;
   reg                           sda_prev_q;
   reg                           locked_prev_q;
   reg                           done_prev_q;
   reg  [2:0]                    state_q;
   reg  [3:0]                    bit_cnt_q;
   reg  [7:0]                    shift_q;
   reg  [7:0]                    tx_q;
   reg  [7:0]                    ptr_q;
   reg                           ptr_set_q;
   reg                           rw_q;
   reg                           nack_q;
   reg                           wr_stb;
   reg  [7:0]                    wr_addr;
   reg  [7:0]                    wr_data;
   reg  [7:0]                    lock_setup_q;
   reg  [7:0]                    reset_config_q;
   reg  [7:0]                    output_config_q;
   reg                           static_lost_q;
   reg                           measure_done_q;

   cdr_sync_2ff
   #(
      .WIDTH (IN_W)
   )
   u_sync
   (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({scl_i, sda_i, saddr5_i, locked_i, signal_lost_i, measure_done_i,
                   suppress_i, freq_word_i, coarse_rate_i}),
      .sync_o    (in_sync)
   );

   assign {scl_s, sda_s, saddr5_s, locked_s, lost_s, done_s, suppress_s, freq_s, coarse_s} =
          in_sync;

   wire scl_rise   = scl_s & ~scl_prev_q;
   wire scl_fall   = ~scl_s & scl_prev_q;
   wire bus_start  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire bus_stop   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   wire [6:0] my_addr = {BASE_ADDR[6], saddr5_s, BASE_ADDR[4:0]};

   // Register read multiplexer, shared by every read byte.
   function [7:0] reg_read;
      input [7:0] addr;
      begin
         case (addr)
            `ADDR_FREQ_LOW:        reg_read = freq_s[7:0];
            `ADDR_FREQ_MID:        reg_read = freq_s[15:8];
            `ADDR_FREQ_HIGH:       reg_read = {1'b0, freq_s[22:16]};
            `ADDR_COARSE_RATE:     reg_read = coarse_s[8:1];
            `ADDR_LINK_STATUS:     reg_read = {2'b00, lost_s, static_lost_q, ~locked_s,
                                               measure_done_q, 1'b0, coarse_s[0]};
            `ADDR_LOCK_SETUP_RB:   reg_read = lock_setup_q;
            `ADDR_RESET_CONFIG_RB: reg_read = reset_config_q;
            default:               reg_read = 8'h00;
         endcase
      end
   endfunction

   wire [7:0] rd_cur  = reg_read(ptr_q);
   wire [7:0] rd_next = reg_read(ptr_q + 8'h01);

   // Bus slave: samples on rising bus clock, changes the data line on falling bus clock.
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         tx_q       <= 8'h00;
         ptr_q      <= 8'h00;
         ptr_set_q  <= 1'b0;
         rw_q       <= 1'b0;
         nack_q     <= 1'b0;
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
         wr_stb     <= 1'b0;
         wr_addr    <= 8'h00;
         wr_data    <= 8'h00;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         sda_o      <= 1'b0;
         wr_stb     <= 1'b0;
         if (bus_start)
         begin
            state_q    <= ST_ADDR;
            bit_cnt_q  <= 4'h0;
            sda_oe_n_o <= 1'b1;
         end
         else if (bus_stop)
         begin
            state_q    <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
         end
         else if (scl_rise)
         begin
            if (state_q == ST_ADDR || state_q == ST_WBYTE)
            begin
               shift_q   <= {shift_q[6:0], sda_s};
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            else if (state_q == ST_RACK)
               nack_q <= sda_s;
         end
         else if (scl_fall)
         begin
            case (state_q)
               ST_ADDR:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     if (shift_q[7:1] == my_addr)
                     begin
                        rw_q       <= shift_q[0];
                        ptr_set_q  <= 1'b0;
                        sda_oe_n_o <= 1'b0;
                        state_q    <= ST_ADDR_ACK;
                     end
                     else
                        state_q <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK:
               begin
                  bit_cnt_q <= 4'h0;
                  if (rw_q)
                  begin
                     sda_oe_n_o <= rd_cur[7];
                     tx_q       <= {rd_cur[6:0], 1'b0};
                     bit_cnt_q  <= 4'h1;
                     state_q    <= ST_READ;
                  end
                  else
                  begin
                     sda_oe_n_o <= 1'b1;
                     state_q    <= ST_WBYTE;
                  end
               end
               ST_WBYTE:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     if (!ptr_set_q)
                     begin
                        ptr_q     <= shift_q;
                        ptr_set_q <= 1'b1;
                     end
                     else
                     begin
                        wr_stb  <= 1'b1;
                        wr_addr <= ptr_q;
                        wr_data <= shift_q;
                        ptr_q   <= ptr_q + 8'h01;
                     end
                     sda_oe_n_o <= 1'b0;
                     state_q    <= ST_WACK;
                  end
               end
               ST_WACK:
               begin
                  sda_oe_n_o <= 1'b1;
                  bit_cnt_q  <= 4'h0;
                  state_q    <= ST_WBYTE;
               end
               ST_READ:
               begin
                  if (bit_cnt_q == 4'h8)
                  begin
                     sda_oe_n_o <= 1'b1;
                     state_q    <= ST_RACK;
                  end
                  else
                  begin
                     sda_oe_n_o <= tx_q[7];
                     tx_q       <= {tx_q[6:0], 1'b0};
                     bit_cnt_q  <= bit_cnt_q + 4'h1;
                  end
               end
               ST_RACK:
               begin
                  if (nack_q)
                     state_q <= ST_IDLE;
                  else
                  begin
                     ptr_q      <= ptr_q + 8'h01;
                     sda_oe_n_o <= rd_next[7];
                     tx_q       <= {rd_next[6:0], 1'b0};
                     bit_cnt_q  <= 4'h1;
                     state_q    <= ST_READ;
                  end
               end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // A reset bit acts when a held one is written to zero.
   wire rc_write     = wr_stb && (wr_addr == `ADDR_RESET_CONFIG);
   wire clr_lost     = rc_write && reset_config_q[`RC_CLEAR_LOCK_LOST] &&
                       !wr_data[`RC_CLEAR_LOCK_LOST];
   wire clr_measure  = rc_write && reset_config_q[`RC_CLEAR_MEASURE] &&
                       !wr_data[`RC_CLEAR_MEASURE];
   wire soft_reset   = rc_write && reset_config_q[`RC_SYSTEM_RESET] &&
                       !wr_data[`RC_SYSTEM_RESET];
   wire start_meas   = wr_stb && (wr_addr == `ADDR_LOCK_SETUP) &&
                       wr_data[`LS_MEASURE];
   wire lock_fell    = locked_prev_q & ~locked_s;
   wire done_rose    = done_s & ~done_prev_q;

   // Control registers and sticky status flags.
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_setup_q    <= `CTRL_RESET_VAL;
         reset_config_q  <= `CTRL_RESET_VAL;
         output_config_q <= `CTRL_RESET_VAL;
         static_lost_q   <= 1'b0;
         measure_done_q  <= 1'b0;
         locked_prev_q   <= 1'b0;
         done_prev_q     <= 1'b0;
         measure_start_o <= 1'b0;
         system_reset_o  <= 1'b0;
      end
      else
      begin
         locked_prev_q   <= locked_s;
         done_prev_q     <= done_s;
         measure_start_o <= start_meas;
         system_reset_o  <= soft_reset;
         if (soft_reset)
         begin
            lock_setup_q    <= `CTRL_RESET_VAL;
            reset_config_q  <= `CTRL_RESET_VAL;
            output_config_q <= `CTRL_RESET_VAL;
            static_lost_q   <= 1'b0;
            measure_done_q  <= 1'b0;
         end
         else
         begin
            if (wr_stb && wr_addr == `ADDR_LOCK_SETUP)
               lock_setup_q <= wr_data;
            if (rc_write)
               reset_config_q <= wr_data;
            if (wr_stb && wr_addr == `ADDR_OUTPUT_CONFIG)
               output_config_q <= wr_data;
            // A new loss of lock in the clearing cycle keeps the flag set.
            if (lock_fell)
               static_lost_q <= 1'b1;
            else if (clr_lost)
               static_lost_q <= 1'b0;
            // Completion beats both the start of a new run and the clear.
            if (done_rose)
               measure_done_q <= 1'b1;
            else if (start_meas || clr_measure)
               measure_done_q <= 1'b0;
         end
      end
   end

   assign ref_range_o   = lock_setup_q[`LS_RANGE_HI:`LS_RANGE_LO];
   assign div_exp_o     = lock_setup_q[`LS_DIV_HI:`LS_DIV_LO];
   assign lock_to_ref_o = lock_setup_q[`LS_LOCK_TO_REF];

   // Output pins.
   always @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_lost_o     <= 1'b0;
         signal_lost_o   <= 1'b0;
         suppress_clk_o  <= 1'b0;
         suppress_data_o <= 1'b0;
      end
      else
      begin
         lock_lost_o     <= reset_config_q[`RC_LOCK_LOST_STATIC] ? static_lost_q
                                                                 : ~locked_s;
         signal_lost_o   <= lost_s ^ output_config_q[`OC_SIGNAL_LOST_LOW];
         // Split mode keeps the clock running and silences only the data.
         suppress_clk_o  <= suppress_s & ~output_config_q[`OC_SUPPRESS_SPLIT];
         suppress_data_o <= suppress_s;
      end
   end

endmodule

// [cdr_regs_consts.vh]
// Register map, field positions and reset values of the recovery-receiver register bank.
// Included by the register bank and its two-wire management slave; definitions only.
`ifndef CDR_REGS_CONSTS_VH
`define CDR_REGS_CONSTS_VH

// Register addresses.
`define ADDR_FREQ_LOW          8'h00
`define ADDR_FREQ_MID          8'h01
`define ADDR_FREQ_HIGH         8'h02
`define ADDR_COARSE_RATE       8'h03
`define ADDR_LINK_STATUS       8'h04
`define ADDR_LOCK_SETUP_RB     8'h05
`define ADDR_RESET_CONFIG_RB   8'h06
`define ADDR_LOCK_SETUP        8'h08
`define ADDR_RESET_CONFIG      8'h09
`define ADDR_OUTPUT_CONFIG     8'h11

// Reset value of every writable register.
`define CTRL_RESET_VAL         8'h00

// Status byte fields.
`define STAT_SIGNAL_LOST       5
`define STAT_STATIC_LOCK_LOST  4
`define STAT_ACQUIRING         3
`define STAT_MEASURE_DONE      2
`define STAT_COARSE_LSB        0

// Lock setup fields.
`define LS_RANGE_HI            7
`define LS_RANGE_LO            6
`define LS_DIV_HI              5
`define LS_DIV_LO              2
`define LS_MEASURE             1
`define LS_LOCK_TO_REF         0

// Reset and configuration fields.
`define RC_LOCK_LOST_STATIC    7
`define RC_CLEAR_LOCK_LOST     6
`define RC_SYSTEM_RESET        5
`define RC_CLEAR_MEASURE       3

// Output configuration fields.
`define OC_SIGNAL_LOST_LOW     2
`define OC_SUPPRESS_SPLIT      1

// Field widths.
`define FREQ_WORD_W            23
`define COARSE_RATE_W          9

`endif

// [cdr_sync_2ff.v]
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; a multi-bit word may be seen torn while it changes.
`timescale 1ns/1ps

module cdr_sync_2ff
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input  wire             sys_clk_i,
   input  wire             rst_n_i,
   // Levels from another domain
   input  wire [WIDTH-1:0] async_i,
   // Synchronised levels
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : bit_sync
         always @(posedge sys_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end
            else
            begin
               meta_q[g] <= async_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;

endmodule

// [cdr_control_status_regs_properties.sv]
// Pin-level checks for the recovery-receiver register bank.
// Bound to the bank; it sees only the bank's ports.
`timescale 1ns/1ps

module cdr_control_status_regs_properties
(
   // Clock, reset and bus clock
   input wire logic       sys_clk_i,
   input wire logic       rst_n_i,
   input wire logic       scl_i,
   // Loop status inputs
   input wire logic       locked_i,
   input wire logic       signal_lost_i,
   input wire logic       suppress_i,
   // Outputs under check
   input wire logic [1:0] ref_range_o,
   input wire logic [3:0] div_exp_o,
   input wire logic       lock_to_ref_o,
   input wire logic       measure_start_o,
   input wire logic       system_reset_o,
   input wire logic       lock_lost_o,
   input wire logic       signal_lost_o,
   input wire logic       suppress_clk_o,
   input wire logic       suppress_data_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   wire logic [6:0] setup = {ref_range_o, div_exp_o, lock_to_ref_o};

   property p_reset_clear; !$past(rst_n_i) |-> setup == 7'h00 && !measure_start_o; endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("setup not reset");
   // Writes land with the bus clock low; an idle bus leaves setup alone.
   property p_setup_hold; scl_i [*8] |=> $stable(setup); endproperty
   a_setup_hold: assert property (p_setup_hold) else $error("setup moved");
   property p_measure_pulse; measure_start_o |=> !measure_start_o; endproperty
   a_measure_pulse: assert property (p_measure_pulse) else $error("long measure");
   property p_sys_reset; system_reset_o |-> ##[0:2] setup == 7'h00 ##1 !system_reset_o; endproperty
   a_sys_reset: assert property (p_sys_reset) else $error("setup kept");
   property p_lock_pin; $fell(locked_i) ##1 !locked_i [*6] |-> lock_lost_o; endproperty
   a_lock_pin: assert property (p_lock_pin) else $error("lock pin low");
   property p_loss_follow; $rose(signal_lost_i) |-> ##[1:6] $changed(signal_lost_o); endproperty
   a_loss_follow: assert property (p_loss_follow) else $error("loss pin stuck");
   property p_no_suppress; !suppress_i [*5] |-> !suppress_clk_o && !suppress_data_o; endproperty
   a_no_suppress: assert property (p_no_suppress) else $error("stray suppress");
   property p_suppress_data; suppress_i [*5] |-> suppress_data_o; endproperty
   a_suppress_data: assert property (p_suppress_data) else $error("data not suppressed");
   property p_clk_with_data; suppress_clk_o |-> suppress_data_o; endproperty
   a_clk_with_data: assert property (p_clk_with_data) else $error("clock alone");

   c_measure: cover property (measure_start_o);
   c_sys_reset: cover property (system_reset_o);
   c_split: cover property (suppress_data_o && !suppress_clk_o);
endmodule

bind cdr_control_status_regs cdr_control_status_regs_properties u_cdr_control_status_regs_properties
(
   .sys_clk_i, .rst_n_i, .scl_i, .locked_i, .signal_lost_i, .suppress_i,
   .ref_range_o, .div_exp_o, .lock_to_ref_o, .measure_start_o, .system_reset_o,
   .lock_lost_o, .signal_lost_o, .suppress_clk_o, .suppress_data_o
);

// [i2c_host_model.sv]
// Two-wire bus master acting as host of the register bank.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps

module i2c_host_model
(
   // Clock
   input  wire logic sys_clk_i,
   // Bus wires
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Two system cycles are a quarter of the 800 ns bus period.
   task automatic q();
      repeat (2) @(posedge sys_clk_i);
   endtask

   // Late clock rise lets a slave still holding its acknowledge let go.
   task automatic start();
      q();
      sda_low_o <= 1'b0;
      q();
      q();
      scl_o <= 1'b1;
      q();
      sda_low_o <= 1'b1;
      q();
      scl_o <= 1'b0;
   endtask

   task automatic stop();
      q();
      sda_low_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      sda_low_o <= 1'b0;
      q();
   endtask

   // Data moves mid-low phase and is read at the end of the high phase.
   task automatic bit_io(input logic b, output logic r);
      q();
      sda_low_o <= ~b;
      q();
      scl_o <= 1'b1;
      q();
      q();
      r = sda_i;
      scl_o <= 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                          output logic nack);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(last, nack);
   endtask

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
      logic [7:0] rx;
      logic       n0, n1, n2;
      start();
      byte_io({dev, 1'b0}, 1'b1, rx, n0);
      byte_io(a, 1'b1, rx, n1);
      byte_io(d, 1'b1, rx, n2);
      stop();
      ok = !(n0 | n1 | n2);
   endtask

   task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
      logic [7:0] rx;
      logic       n;
      start();
      byte_io({dev, 1'b0}, 1'b1, rx, n);
      byte_io(a, 1'b1, rx, n);
      start();
      byte_io({dev, 1'b1}, 1'b1, rx, n);
      byte_io(8'hff, 1'b1, d, n);
      stop();
   endtask
endmodule

// [cdr_control_status_regs_tb_top.sv]
// Self-checking bench for the recovery-receiver register bank.
// Assumes the host model and the bound checker alongside.
`timescale 1ns/1ps
`include "cdr_regs_consts.vh"

module cdr_control_status_regs_tb_top;
   typedef struct packed
   {
      logic [7:0] d;
      logic [1:0] rng;
      logic [8:0] ratio;
      logic       lref;
      logic       meas;
   } row_t;

   logic                      sys_clk_i = 1'b0;
   logic                      rst_n_i = 1'b0;
   logic                      saddr5_i = 1'b0;
   logic                      locked_i = 1'b1;
   logic                      signal_lost_i = 1'b0;
   logic                      measure_done_i = 1'b0;
   logic [`FREQ_WORD_W-1:0]   freq_word_i = 23'h000000;
   logic [`COARSE_RATE_W-1:0] coarse_rate_i = 9'h000;
   logic                      suppress_i = 1'b0;
   logic                      scl;
   logic                      sda_low;
   logic                      sda_o;
   logic                      sda_oe_n_o;
   logic [1:0]                ref_range_o;
   logic [3:0]                div_exp_o;
   logic                      lock_to_ref_o;
   logic                      measure_start_o;
   logic                      system_reset_o;
   logic                      lock_lost_o;
   logic                      signal_lost_o;
   logic                      suppress_clk_o;
   logic                      suppress_data_o;
   logic [6:0]                dev = 7'h40;
   int                        err_count = 0;
   int                        compares = 0;
   int                        meas_cnt = 0;
   int                        rst_cnt = 0;
   row_t rows [5] = '{'{8'hc0, 2'h3, 9'h001, 1'b0, 1'b0}, '{8'h60, 2'h1, 9'h100, 1'b0, 1'b0},
                      '{8'h1d, 2'h0, 9'h080, 1'b1, 1'b0}, '{8'h96, 2'h2, 9'h020, 1'b0, 1'b1},
                      '{8'h0e, 2'h0, 9'h008, 1'b0, 1'b1}};
   logic [7:0] oc [3] = '{8'h00, 8'h04, 8'h06};
   logic [2:0] oe [3] = '{3'h7, 3'h3, 3'h1};
   wire logic sda_w = !sda_low && (sda_oe_n_o || sda_o);

   always #50 sys_clk_i = ~sys_clk_i;

   always @(posedge sys_clk_i)
   begin
      if (measure_start_o === 1'b1)
         meas_cnt++;
      if (system_reset_o === 1'b1)
         rst_cnt++;
   end

   cdr_control_status_regs #(.BASE_ADDR(7'h40)) u_cdr_control_status_regs
   (
      .sys_clk_i, .rst_n_i, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_n_o, .saddr5_i,
      .locked_i, .signal_lost_i, .measure_done_i, .freq_word_i, .coarse_rate_i, .suppress_i,
      .ref_range_o, .div_exp_o, .lock_to_ref_o, .measure_start_o, .system_reset_o,
      .lock_lost_o, .signal_lost_o, .suppress_clk_o, .suppress_data_o
   );

   i2c_host_model u_i2c_host_model (.sys_clk_i, .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

   task automatic chk(input string name, input logic [15:0] exp, got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      logic ok;
      u_i2c_host_model.write_reg(dev, a, d, ok);
      chk("ack", 16'h0001, 16'(ok));
   endtask

   task automatic rd(input string name, input logic [7:0] a, m, e);
      logic [7:0] v;
      u_i2c_host_model.read_reg(dev, a, v);
      chk(name, 16'(e), 16'(v & m));
   endtask

   // Two sync stages and a register take under eight cycles.
   task automatic settle();
      repeat (8) @(posedge sys_clk_i);
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      #5000000;
      err_count++;
      $display("mismatch watchdog expected finish seen hang");
      summarize();
   end

   initial
   begin
      row_t r;
      int   m;
      logic ok;
      repeat (20) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      foreach (rows[i])
      begin
         r = rows[i];
         m = meas_cnt;
         wr(`ADDR_LOCK_SETUP, r.d);
         chk("setup", 16'({r.rng, r.ratio, r.lref, r.meas}),
             16'({ref_range_o, 9'h001 << div_exp_o, lock_to_ref_o, 1'(meas_cnt - m)}));
         rd("setup rb", `ADDR_LOCK_SETUP_RB, 8'hff, r.d);
      end
      $display("test table done");
      rst_n_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("reset", 16'h0000, 16'({ref_range_o, div_exp_o, lock_to_ref_o}));
      rst_n_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rd("setup rb", `ADDR_LOCK_SETUP_RB, 8'hff, 8'h00);
      rd("config rb", `ADDR_RESET_CONFIG_RB, 8'hff, 8'h00);
      $display("test reset done");
      measure_done_i <= 1'b1;
      coarse_rate_i <= 9'h1a5;
      freq_word_i <= 23'h7a3c7e;
      signal_lost_i <= 1'b1;
      locked_i <= 1'b0;
      rd("status", `ADDR_LINK_STATUS, 8'h3d, 8'h3d);
      rd("coarse", `ADDR_COARSE_RATE, 8'hff, 8'hd2);
      rd("freq lo", `ADDR_FREQ_LOW, 8'hff, 8'h7e);
      rd("freq mid", `ADDR_FREQ_MID, 8'hff, 8'h3c);
      rd("freq hi", `ADDR_FREQ_HIGH, 8'hff, 8'h7a);
      locked_i <= 1'b1;
      signal_lost_i <= 1'b0;
      rd("status", `ADDR_LINK_STATUS, 8'h3d, 8'h15);
      wr(`ADDR_RESET_CONFIG, 8'h40);
      wr(`ADDR_RESET_CONFIG, 8'h00);
      rd("status", `ADDR_LINK_STATUS, 8'h3d, 8'h05);
      wr(`ADDR_RESET_CONFIG, 8'h08);
      rd("status", `ADDR_LINK_STATUS, 8'h3d, 8'h05);
      wr(`ADDR_RESET_CONFIG, 8'h00);
      rd("status", `ADDR_LINK_STATUS, 8'h3d, 8'h01);
      measure_done_i <= 1'b0;
      $display("test status done");
      wr(`ADDR_RESET_CONFIG, 8'h80);
      rd("config rb", `ADDR_RESET_CONFIG_RB, 8'hff, 8'h80);
      locked_i <= 1'b0;
      settle();
      chk("lol", 16'h0001, 16'(lock_lost_o));
      @(posedge sys_clk_i);
      locked_i <= 1'b1;
      settle();
      chk("lol", 16'h0001, 16'(lock_lost_o));
      wr(`ADDR_RESET_CONFIG, 8'hc0);
      wr(`ADDR_RESET_CONFIG, 8'h80);
      chk("lol", 16'h0000, 16'(lock_lost_o));
      wr(`ADDR_RESET_CONFIG, 8'h00);
      locked_i <= 1'b0;
      settle();
      chk("lol", 16'h0001, 16'(lock_lost_o));
      @(posedge sys_clk_i);
      locked_i <= 1'b1;
      settle();
      chk("lol", 16'h0000, 16'(lock_lost_o));
      $display("test lock pin done");
      signal_lost_i <= 1'b1;
      suppress_i <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         wr(`ADDR_OUTPUT_CONFIG, oc[k]);
         settle();
         chk("pins", 16'(oe[k]), 16'({signal_lost_o, suppress_clk_o, suppress_data_o}));
      end
      @(posedge sys_clk_i);
      suppress_i <= 1'b0;
      signal_lost_i <= 1'b0;
      settle();
      chk("pins", 16'h0004, 16'({signal_lost_o, suppress_clk_o, suppress_data_o}));
      $display("test outputs done");
      m = rst_cnt;
      wr(`ADDR_LOCK_SETUP, 8'h55);
      wr(`ADDR_RESET_CONFIG, 8'h20);
      rd("setup rb", `ADDR_LOCK_SETUP_RB, 8'hff, 8'h55);
      chk("sys rst", 16'(m), 16'(rst_cnt));
      wr(`ADDR_RESET_CONFIG, 8'h00);
      chk("sys rst", 16'(m + 1), 16'(rst_cnt));
      rd("setup rb", `ADDR_LOCK_SETUP_RB, 8'hff, 8'h00);
      $display("test system reset done");
      rd("unmapped", 8'h07, 8'hff, 8'h00);
      wr(`ADDR_FREQ_LOW, 8'h00);
      rd("freq lo", `ADDR_FREQ_LOW, 8'hff, 8'h7e);
      saddr5_i <= 1'b1;
      u_i2c_host_model.write_reg(dev, `ADDR_LOCK_SETUP, 8'h01, ok);
      chk("foreign ack", 16'h0000, 16'(ok));
      dev = 7'h60;
      wr(`ADDR_LOCK_SETUP, 8'h01);
      rd("setup rb", `ADDR_LOCK_SETUP_RB, 8'hff, 8'h01);
      $display("test refusal done");
      summarize();
   end
endmodule
